// >>> verilog/rx_front_pkg.sv
`default_nettype none
// ============================================================
// shared constants for the receive front end
package rx_front_pkg;

    // register pages: byte address = page base + 4 * index
    localparam logic [11:0] PAGE_NOISE_BASE = 12'h000;
    localparam logic [11:0] PAGE_FMT_BASE   = 12'h400;
    localparam logic [7:0]  IDX_MASK_A      = 8'h12;
    localparam logic [7:0]  IDX_MASK_B      = 8'h13;
    localparam logic [7:0]  IDX_MASK_C      = 8'h14;
    localparam logic [7:0]  IDX_MASK_D      = 8'h15;
    localparam logic [7:0]  IDX_STEER       = 8'h10;
    localparam logic [7:0]  IDX_RELOAD      = 8'h11;
    localparam logic [7:0]  IDX_SYNC_CTRL   = 8'h12;
    localparam logic [7:0]  IDX_TIMER_STAT  = 8'h16;

    // reset values
    localparam logic [15:0] MASK_RST        = 16'h0000;
    localparam logic [15:0] STEER_RST       = 16'h0000;
    localparam logic [15:0] RELOAD_RST      = 16'hFFFF;
    localparam logic [15:0] SYNC_CTRL_RST   = 16'hFF80;

    // sync control field positions
    localparam int ZPAD_LSB   = 0;
    localparam int DIAG_LSB   = 4;
    localparam int TTEST_BIT  = 6;
    localparam int TSYNC_LSB  = 7;
    localparam int PSYNC_LSB  = 10;
    localparam int ZSYNC_LSB  = 13;

    // steering nibble bits
    localparam int STEER_Q     = 0;
    localparam int STEER_I_DLY = 1;
    localparam int STEER_I     = 2;
    localparam int STEER_TEST  = 3;

    // diagnostic pattern codes
    typedef enum logic [1:0] {
        DIAG_RAMP   = 2'h0,
        DIAG_ZERO   = 2'h1,
        DIAG_RANDOM = 2'h2,
        DIAG_CONST  = 2'h3
    } diag_t;

    localparam logic [15:0] CONST_PATTERN = 16'h4000;
    localparam logic [15:0] LFSR_SEED     = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS     = 16'hB400;
    localparam int          PULSE_DELAY   = 5;

    function automatic logic [11:0] byte_addr(input logic [11:0] base,
                                              input logic [7:0]  idx);
        byte_addr = base + {2'b00, idx, 2'b00};
    endfunction : byte_addr

endpackage : rx_front_pkg
`default_nettype wire

// >>> verilog/rx_noise_lfsr.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// pseudo-random source for noise and the random pattern
module rx_noise_lfsr (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // control
    input  wire logic        hold_sync,
    // state
    output logic [15:0]      state
);
    logic [15:0] state_ff;
    logic        fb;

    // galois step, reseeded while the sync holds it
    assign fb = state_ff[0];
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= rx_front_pkg::LFSR_SEED;
        end else if (hold_sync) begin
            state_ff <= rx_front_pkg::LFSR_SEED;
        end else begin
            state_ff <= (state_ff >> 1) ^ (fb ? rx_front_pkg::LFSR_TAPS
                                              : 16'h0000);
        end
    end

    assign state = state_ff;

endmodule : rx_noise_lfsr
`default_nettype wire

// >>> verilog/periodic_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// 24-bit repeating down counter with delayed restart pulse
module periodic_timer (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // control
    input  wire logic [15:0] reload_val,
    input  wire logic        test_mode,
    input  wire logic        restart_sync,
    // results
    output logic [23:0]      count,
    output logic             pulse
);
    localparam int PD = rx_front_pkg::PULSE_DELAY;

    logic [23:0]   cnt_ff;
    logic [PD-1:0] dly_ff;
    logic [23:0]   load_val;
    logic          at_end;
    logic          restart;

    // upper bits from the register, lower eight all ones
    assign load_val = {reload_val, 8'hFF};
    // test mode counts the upper bits only
    assign at_end   = test_mode ? (cnt_ff[23:8] == 16'h0000)
                                : (cnt_ff == 24'h000000);
    assign restart  = restart_sync | at_end;

    // count down, reload on end or sync
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 24'hFFFFFF;
        end else if (restart) begin
            cnt_ff <= load_val;
        end else if (test_mode) begin
            cnt_ff <= {cnt_ff[23:8] - 16'h0001, 8'hFF};
        end else begin
            cnt_ff <= cnt_ff - 24'h000001;
        end
    end

    // restart pulse delay line
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dly_ff <= '0;
        end else begin
            dly_ff <= {dly_ff[PD-2:0], restart};
        end
    end

    assign count = cnt_ff;
    assign pulse = dly_ff[PD-1];

    property p_pulse_delay;
        @(posedge clk) disable iff (!arst_n)
        restart |-> ##5 pulse;
    endproperty
    a_pulse_delay: assert property (p_pulse_delay)
        else $error("timer pulse not five clocks after restart");

    property p_sync_reload;
        @(posedge clk) disable iff (!arst_n)
        restart_sync |=> count == {$past(reload_val), 8'hFF};
    endproperty
    a_sync_reload: assert property (p_sync_reload)
        else $error("timer did not reload on sync");

    property p_count_down;
        @(posedge clk) disable iff (!arst_n)
        (!restart && !test_mode) |=> count == $past(count) - 24'h000001;
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("timer did not count down by one");

    c_restart_end: cover property (@(posedge clk) disable iff (!arst_n)
        at_end && !restart_sync);

endmodule : periodic_timer
`default_nettype wire

// >>> verilog/rx_input_formatter.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - set noise mask bits add lfsr noise into that input bit
// - steering nibble bits: Q, delayed I, I, test to both
// - usual codes: 1 Q half, 3 IQ multiplexed, 4 real input
// - steering register holds paths A to D from low to high nibble
// - timer is 24-bit down counter of 256 x (reload + 1), repeating
// - selected sync restarts the timer count
// - timer count is ramp data; pulse five clocks after restart
// - reload field is upper sixteen bits, resets to all ones
// - timer test bit forces low eight count bits high
// - zero pad count N follows each sample with N zeros
// - diagnostic field picks ramp, zero, random or 0x4000
// - bits nine to seven select timer sync, reset seven
// - bits twelve to ten select pattern sync, reset seven
// - bits fifteen to thirteen select zero pad sync, reset seven
module rx_input_formatter (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // apb slave
    input  wire logic [11:0]       paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // sample inputs and sync strobes
    input  wire logic [3:0][15:0]  adc_data,
    input  wire logic [7:0]        sync_strobes,
    // formatted outputs
    output logic [3:0][15:0]       rx_i,
    output logic [3:0][15:0]       rx_q,
    output logic                   rx_valid,
    output logic [23:0]            timer_count,
    output logic                   timer_pulse
);
    // ========================================================
    // address decode
    logic        access;
    logic        setup;
    logic        hit_mask_a;
    logic        hit_mask_b;
    logic        hit_mask_c;
    logic        hit_mask_d;
    logic        hit_steer;
    logic        hit_reload;
    logic        hit_sync;
    logic        hit_stat;
    logic        mapped;
    logic        wr_en;

    assign setup      = psel & ~penable;
    assign access     = psel & penable;
    assign hit_mask_a = paddr == rx_front_pkg::byte_addr(
                        rx_front_pkg::PAGE_NOISE_BASE, rx_front_pkg::IDX_MASK_A);
    assign hit_mask_b = paddr == rx_front_pkg::byte_addr(
                        rx_front_pkg::PAGE_NOISE_BASE, rx_front_pkg::IDX_MASK_B);
    assign hit_mask_c = paddr == rx_front_pkg::byte_addr(
                        rx_front_pkg::PAGE_NOISE_BASE, rx_front_pkg::IDX_MASK_C);
    assign hit_mask_d = paddr == rx_front_pkg::byte_addr(
                        rx_front_pkg::PAGE_NOISE_BASE, rx_front_pkg::IDX_MASK_D);
    assign hit_steer  = paddr == rx_front_pkg::byte_addr(
                        rx_front_pkg::PAGE_FMT_BASE, rx_front_pkg::IDX_STEER);
    assign hit_reload = paddr == rx_front_pkg::byte_addr(
                        rx_front_pkg::PAGE_FMT_BASE, rx_front_pkg::IDX_RELOAD);
    assign hit_sync   = paddr == rx_front_pkg::byte_addr(
                        rx_front_pkg::PAGE_FMT_BASE, rx_front_pkg::IDX_SYNC_CTRL);
    assign hit_stat   = paddr == rx_front_pkg::byte_addr(
                        rx_front_pkg::PAGE_FMT_BASE, rx_front_pkg::IDX_TIMER_STAT);
    assign mapped     = hit_mask_a | hit_mask_b | hit_mask_c | hit_mask_d |
                        hit_steer | hit_reload | hit_sync | hit_stat;
    assign wr_en      = access & pwrite & mapped;

    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // ========================================================
    // registers
    logic [3:0][15:0] mask_ff;
    logic [15:0]      steer_ff;
    logic [15:0]      reload_ff;
    logic [15:0]      sync_ctrl_ff;
    logic [31:0]      prdata_ff;
    logic [3:0]       mask_hits;

    // byte lanes 0 and 1 carry the 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  st);
        merge16 = {st[1] ? wd[15:8] : old[15:8],
                   st[0] ? wd[7:0]  : old[7:0]};
    endfunction : merge16

    assign mask_hits = {hit_mask_d, hit_mask_c, hit_mask_b, hit_mask_a};

    // noise mask registers, one per path
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_ff <= {4{rx_front_pkg::MASK_RST}};
        end else begin
            for (int p = 0; p < 4; p++) begin
                if (wr_en && mask_hits[p]) begin
                    mask_ff[p] <= merge16(mask_ff[p], pwdata, pstrb);
                end
            end
        end
    end

    // steering, reload and sync control registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            steer_ff     <= rx_front_pkg::STEER_RST;
            reload_ff    <= rx_front_pkg::RELOAD_RST;
            sync_ctrl_ff <= rx_front_pkg::SYNC_CTRL_RST;
        end else begin
            if (wr_en && hit_steer) begin
                steer_ff <= merge16(steer_ff, pwdata, pstrb);
            end
            if (wr_en && hit_reload) begin
                reload_ff <= merge16(reload_ff, pwdata, pstrb);
            end
            if (wr_en && hit_sync) begin
                sync_ctrl_ff <= merge16(sync_ctrl_ff, pwdata, pstrb);
            end
        end
    end

    // read data captured in the setup phase
    logic [31:0] rd_mux;
    assign rd_mux = hit_mask_a ? {16'h0000, mask_ff[0]} :
                    hit_mask_b ? {16'h0000, mask_ff[1]} :
                    hit_mask_c ? {16'h0000, mask_ff[2]} :
                    hit_mask_d ? {16'h0000, mask_ff[3]} :
                    hit_steer  ? {16'h0000, steer_ff}   :
                    hit_reload ? {16'h0000, reload_ff}  :
                    hit_sync   ? {16'h0000, sync_ctrl_ff} :
                    hit_stat   ? {8'h00, timer_count}   : 32'h00000000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_ff <= 32'h00000000;
        end else if (setup) begin
            prdata_ff <= rd_mux;
        end
    end
    assign prdata = prdata_ff;

    // ========================================================
    // control fields and sync selection
    logic [3:0]          zpad_n;
    rx_front_pkg::diag_t diag;
    logic                ttest;
    logic                tsync_hit;
    logic                psync_hit;
    logic                zsync_hit;

    assign zpad_n = sync_ctrl_ff[rx_front_pkg::ZPAD_LSB +: 4];
    assign diag   = rx_front_pkg::diag_t'(
                    sync_ctrl_ff[rx_front_pkg::DIAG_LSB +: 2]);
    assign ttest  = sync_ctrl_ff[rx_front_pkg::TTEST_BIT];
    assign tsync_hit = sync_strobes[
                       sync_ctrl_ff[rx_front_pkg::TSYNC_LSB +: 3]];
    assign psync_hit = sync_strobes[
                       sync_ctrl_ff[rx_front_pkg::PSYNC_LSB +: 3]];
    assign zsync_hit = sync_strobes[
                       sync_ctrl_ff[rx_front_pkg::ZSYNC_LSB +: 3]];

    // ========================================================
    // timer and noise source
    logic [15:0] noise;

    periodic_timer u_timer (
        .clk          (clk),
        .arst_n       (arst_n),
        .reload_val   (reload_ff),
        .test_mode    (ttest),
        .restart_sync (tsync_hit),
        .count        (timer_count),
        .pulse        (timer_pulse)
    );

    // the pattern sync holds the generator at its seed
    rx_noise_lfsr u_lfsr (
        .clk       (clk),
        .arst_n    (arst_n),
        .hold_sync (psync_hit),
        .state     (noise)
    );

    // ========================================================
    // test pattern and zero pad sequencing
    logic [15:0] test_data;
    logic [3:0]  pad_cnt_ff;
    logic        pad_slot;

    assign test_data = (diag == rx_front_pkg::DIAG_RAMP)   ? timer_count[15:0] :
                       (diag == rx_front_pkg::DIAG_ZERO)   ? 16'h0000 :
                       (diag == rx_front_pkg::DIAG_RANDOM) ? noise :
                       rx_front_pkg::CONST_PATTERN;

    // slot zero carries a sample, the next N slots carry zeros
    assign pad_slot = pad_cnt_ff == 4'h0;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pad_cnt_ff <= 4'h0;
        end else if (zsync_hit || pad_cnt_ff >= zpad_n) begin
            pad_cnt_ff <= 4'h0;
        end else begin
            pad_cnt_ff <= pad_cnt_ff + 4'h1;
        end
    end

    // ========================================================
    // per path noise injection and steering
    logic [3:0][15:0] noisy;
    logic [3:0][15:0] dly_ff;
    logic [3:0][15:0] i_ff;
    logic [3:0][15:0] q_ff;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_path
            logic [3:0]  sel;
            logic [15:0] nxt_i;
            logic [15:0] nxt_q;

            assign sel       = steer_ff[4*g +: 4];
            assign noisy[g]  = adc_data[g] ^ (mask_ff[g] & noise);
            // test overrides; direct I wins over delayed I
            assign nxt_i = sel[rx_front_pkg::STEER_TEST]  ? test_data :
                           sel[rx_front_pkg::STEER_I]     ? noisy[g]  :
                           sel[rx_front_pkg::STEER_I_DLY] ? dly_ff[g] :
                           16'h0000;
            assign nxt_q = sel[rx_front_pkg::STEER_TEST]  ? test_data :
                           sel[rx_front_pkg::STEER_Q]     ? noisy[g]  :
                           16'h0000;

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    dly_ff[g] <= 16'h0000;
                    i_ff[g]   <= 16'h0000;
                    q_ff[g]   <= 16'h0000;
                end else begin
                    dly_ff[g] <= noisy[g];
                    i_ff[g]   <= pad_slot ? nxt_i : 16'h0000;
                    q_ff[g]   <= pad_slot ? nxt_q : 16'h0000;
                end
            end
        end
    endgenerate

    logic valid_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= pad_slot;
        end
    end

    assign rx_i     = i_ff;
    assign rx_q     = q_ff;
    assign rx_valid = valid_ff;

    // ========================================================
    // checks
    property p_noise_real;
        @(posedge clk) disable iff (!arst_n)
        (pad_slot && steer_ff[3:0] == 4'h4) |=>
            rx_i[0] == $past(adc_data[0] ^ (mask_ff[0] & noise));
    endproperty
    a_noise_real: assert property (p_noise_real)
        else $error("path A real input lost its noise mix");

    property p_steer_q;
        @(posedge clk) disable iff (!arst_n)
        (pad_slot && steer_ff[7:4] == 4'h1) |=>
            (rx_i[1] == 16'h0000 &&
             rx_q[1] == $past(adc_data[1] ^ (mask_ff[1] & noise)));
    endproperty
    a_steer_q: assert property (p_steer_q)
        else $error("path B code one did not route to Q only");

    property p_steer_dly;
        @(posedge clk) disable iff (!arst_n)
        (pad_slot && steer_ff[3:0] == 4'h2 && $stable(mask_ff[0])) |=>
            rx_i[0] == $past(adc_data[0] ^ (mask_ff[0] & noise), 2);
    endproperty
    a_steer_dly: assert property (p_steer_dly)
        else $error("delayed I path not one sample late");

    property p_pad_gap;
        @(posedge clk) disable iff (!arst_n)
        (pad_slot && zpad_n == 4'h2 && !zsync_hit && !wr_en) ##1
            (!zsync_hit && !wr_en) |=> !pad_slot ##1 pad_slot;
    endproperty
    a_pad_gap: assert property (p_pad_gap)
        else $error("zero pad of two not followed by sample slot");

    property p_pad_zero;
        @(posedge clk) disable iff (!arst_n)
        !pad_slot |=> (rx_i == '0 && rx_q == '0 && !rx_valid);
    endproperty
    a_pad_zero: assert property (p_pad_zero)
        else $error("pad slot carried nonzero data");

    property p_const_pat;
        @(posedge clk) disable iff (!arst_n)
        (pad_slot && diag == rx_front_pkg::DIAG_CONST &&
         steer_ff[15:12] == 4'h8) |=>
            (rx_i[3] == 16'h4000 && rx_q[3] == 16'h4000);
    endproperty
    a_const_pat: assert property (p_const_pat)
        else $error("constant pattern not 0x4000 on both halves");

    property p_steer_write;
        @(posedge clk) disable iff (!arst_n)
        (wr_en && hit_steer && pstrb[1:0] == 2'b11) |=>
            steer_ff == $past(pwdata[15:0]);
    endproperty
    a_steer_write: assert property (p_steer_write)
        else $error("steering register write not stored");

    property p_zsync_align;
        @(posedge clk) disable iff (!arst_n)
        zsync_hit |=> pad_slot;
    endproperty
    a_zsync_align: assert property (p_zsync_align)
        else $error("zero pad sync did not realign to a sample slot");

    c_iq_mux: cover property (@(posedge clk) disable iff (!arst_n)
        pad_slot && steer_ff[3:0] == 4'h3);
    c_random: cover property (@(posedge clk) disable iff (!arst_n)
        diag == rx_front_pkg::DIAG_RANDOM && mask_ff[0] != 16'h0000);
    c_pulse: cover property (@(posedge clk) disable iff (!arst_n)
        timer_pulse);

endmodule : rx_input_formatter
`default_nettype wire

// >>> test/adc_source.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// sample source standing in for the four converter buses
module adc_source (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // sample buses, paths a to d
    output logic [3:0][15:0] adc_data
);
    integer seed = 96732;
    // fresh random sample on every path each clock, so no stale value
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            adc_data <= '0;
        else
            adc_data <= {$random(seed), $random(seed)};
    end
endmodule : adc_source
`default_nettype wire

// >>> test/rx_input_formatter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rx_input_formatter_tb;
    logic             clk = 0;
    logic             arst_n = 0;
    logic [11:0]      paddr = '0;
    logic             psel = 0, penable = 0, pwrite = 0;
    logic [31:0]      pwdata = '0;
    logic [31:0]      prdata;
    logic             pready, pslverr, rx_valid, timer_pulse;
    logic [3:0][15:0] adc_data, rx_i, rx_q, h1, h2;
    logic [7:0]       sync_strobes = '0;
    logic [23:0]      timer_count;
    logic [17:0]      expq [$];
    logic [17:0]      x;
    logic [15:0]      d;
    logic [11:0]      a;
    logic [7:0]       v;
    integer           bad_count = 0, n_checks = 0, seed = 96732, i, j;
    // ============================================================
    // design, sample source and clock
    rx_input_formatter dut (.clk(clk), .arst_n(arst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_data(adc_data), .sync_strobes(sync_strobes), .rx_i(rx_i),
        .rx_q(rx_q), .rx_valid(rx_valid), .timer_count(timer_count),
        .timer_pulse(timer_pulse));
    adc_source src (.clk(clk), .arst_n(arst_n), .adc_data(adc_data));
    always #4 clk = ~clk;
    // sample history: h1 is the sample taken at the last edge
    always @(negedge clk) begin
        h2 <= h1;
        h1 <= adc_data;
    end
    // ============================================================
    // checking and reporting
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    // completed transfers are matched against the oldest note
    always @(posedge clk) if (psel && penable && pready) begin
        x = expq.pop_front();
        chk(pslverr === x[16], "error response");
        if (!x[17]) chk(prdata === {16'h0000, x[15:0]}, "read data");
    end
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [15:0] dd, input logic e);
        integer k;
        expq.push_back({w, e, dd});
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {16'h0000, dd};
        @(posedge clk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        chk(k == 1, "wait states");
        if (k >= 50) begin
            chk(1'b0, "apb hang");
            wrap_up();
        end
        psel <= 0;
        penable <= 0;
    endtask : apb
    // steer paths a, b and d with one code; check Q on all three and I on path a only
    task automatic steer(input logic [3:0] c);
        apb(1, 12'h440, {c, 4'h0, c, c}, 0);
        repeat (3) @(negedge clk);
        repeat (4) begin
            @(negedge clk);
            chk(rx_q[0] === (c[0] ? h1[0] : 16'h0000), "q a");
            chk(rx_i[0] === (c[2] ? h1[0] : c[1] ? h2[0] : 16'h0000),
                "i a");
            chk(rx_q[3] === (c[0] ? h1[3] : 16'h0000), "q d");
            chk(rx_q[1] === (c[0] ? h1[1] : 16'h0000), "q b");
            chk(rx_valid === 1'b1, "valid");
        end
    endtask : steer
    // ============================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1;
        apb(0, 12'h440, 16'h0000, 0);
        apb(0, 12'h444, 16'hFFFF, 0);
        apb(0, 12'h448, 16'hFF80, 0);
        apb(0, 12'h7FC, 16'h0000, 1);
        apb(1, 12'h7FC, 16'h1234, 1);
        for (i = 0; i < 4; i++) begin
            a = 12'h048 + 12'(4 * i);
            d = 16'($random(seed));
            apb(0, a, 16'h0000, 0);
            apb(1, a, d, 0);
            apb(0, a, d, 0);
            apb(1, a, 16'h0000, 0);
        end
        for (i = 1; i < 5; i++) steer(4'(i));
        apb(1, 12'h440, 16'h8008, 0);
        for (j = 0; j < 4; j++) begin
            apb(1, 12'h448, 16'hFF80 | 16'(j << 4), 0);
            repeat (3) @(negedge clk);
            d = rx_i[0];
            @(negedge clk);
            chk(rx_q[0] === rx_i[0], "test both");
            chk(rx_i[3] === rx_i[0] && rx_q[3] === rx_i[0], "test d");
            if (j == 0) chk(rx_i[0] === d - 16'h0001, "ramp");
            if (j == 1) chk(rx_i[0] === 16'h0000, "zero");
            if (j == 3) chk(rx_i[0] === 16'h4000, "const");
        end
        apb(1, 12'h440, 16'h0001, 0);
        apb(1, 12'h448, 16'hFF82, 0);
        repeat (3) @(negedge clk);
        for (j = 0; j < 6; j++) begin
            @(negedge clk);
            v[j] = rx_valid;
            if (!rx_valid) chk(rx_q[0] === 16'h0000, "pad zero");
        end
        chk($countones(v[5:0]) == 2 && v[5:3] === v[2:0], "pad");
        apb(1, 12'h448, 16'hFFA0, 0);
        apb(1, 12'h048, 16'h0001, 0);
        repeat (3) @(negedge clk);
        v = 0;
        for (j = 0; j < 16; j++) begin
            @(negedge clk);
            d = rx_q[0] ^ h1[0];
            chk((d & 16'hFFFE) === 16'h0000, "unmasked bits");
            v[0] = v[0] | d[0];
        end
        chk(v[0] === 1'b1, "noise seen");
        // pattern and zero pad syncs: seed held, pad phase restarted
        apb(1, 12'h440, 16'h0008, 0);
        apb(1, 12'h448, 16'hD7A2, 0);
        @(posedge clk);
        sync_strobes <= 8'h60;
        repeat (3) @(posedge clk);
        sync_strobes <= 8'h00;
        v = 0;
        for (j = 0; j < 5; j++) begin
            @(negedge clk);
            v[j] = rx_valid;
            if (j < 2)
                chk(rx_i[0] === rx_front_pkg::LFSR_SEED, "seed");
        end
        chk(v === 8'h13, "pad realign");
        apb(1, 12'h444, 16'h0002, 0);
        for (i = 0; i < 8; i++) begin
            apb(1, 12'h448, 16'hFC00 | 16'(i << 7), 0);
            @(posedge clk);
            sync_strobes <= 8'(1 << i);
            @(posedge clk);
            sync_strobes <= 8'h00;
            v = 0;
            for (j = 1; j < 8; j++) begin
                @(negedge clk);
                v[j] = timer_pulse;
                chk(timer_count === 24'h0002FF - 24'(j - 1), "count");
            end
            chk(v === 8'h20, "pulse");
        end
        repeat (761) @(negedge clk);
        chk(timer_count === 24'h000000, "end");
        @(negedge clk);
        chk(timer_count === 24'h0002FF, "reload");
        apb(0, 12'h458, 16'h02FE, 0);
        apb(1, 12'h448, 16'hFFC0, 0);
        @(posedge clk);
        sync_strobes <= 8'h80;
        @(posedge clk);
        sync_strobes <= 8'h00;
        @(negedge clk);
        chk(timer_count === 24'h0002FF, "test load");
        @(negedge clk);
        chk(timer_count === 24'h0001FF, "test step");
        wrap_up();
    end
endmodule : rx_input_formatter_tb
`default_nettype wire
